// ### gpm_pkg.sv
// Package: register map, reset values and carrier types of the pad block
package gpm_pkg;

  localparam int unsigned GPM_PINS = 8;

  // Register byte offsets
  localparam logic [11:0] GPM_OFF_DATA  = 12'h000;
  localparam logic [11:0] GPM_OFF_DIR   = 12'h400;
  localparam logic [11:0] GPM_OFF_ALT   = 12'h420;
  localparam logic [11:0] GPM_OFF_DR2   = 12'h500;
  localparam logic [11:0] GPM_OFF_DR4   = 12'h504;
  localparam logic [11:0] GPM_OFF_DR8   = 12'h508;
  localparam logic [11:0] GPM_OFF_OD    = 12'h50c;
  localparam logic [11:0] GPM_OFF_PU    = 12'h510;
  localparam logic [11:0] GPM_OFF_PD    = 12'h514;

  // Field position of the eight pin bits
  localparam int unsigned GPM_FIELD_LSB = 0;
  localparam int unsigned GPM_FIELD_MSB = 7;

  // Reset values
  localparam logic [7:0] GPM_RST_DATA  = 8'h00;
  localparam logic [7:0] GPM_RST_DIR   = 8'h00;
  localparam logic [7:0] GPM_RST_ALT   = 8'h00;
  localparam logic [7:0] GPM_RST_ALT_B = 8'h80;
  localparam logic [7:0] GPM_RST_ALT_C = 8'h0f;
  localparam logic [7:0] GPM_RST_DR2   = 8'hff;
  localparam logic [7:0] GPM_RST_DR4   = 8'h00;
  localparam logic [7:0] GPM_RST_DR8   = 8'h00;
  localparam logic [7:0] GPM_RST_OD    = 8'h00;
  localparam logic [7:0] GPM_RST_PU    = 8'hff;
  localparam logic [7:0] GPM_RST_PD    = 8'h00;
  localparam logic [31:0] GPM_RDATA_NONE = 32'h0000_0000;

  // Pad configuration forwarded to the pads
  typedef struct packed {
    logic [7:0] drive_2ma_bits;
    logic [7:0] drive_4ma_bits;
    logic [7:0] drive_8ma_bits;
    logic [7:0] od;
    logic [7:0] pu;
    logic [7:0] pd;
  } gpm_pad_cfg_t;

  // Clears owed to the other fields of a group
  typedef struct packed {
    logic [7:0] drive_2ma_bits;
    logic [7:0] drive_4ma_bits;
    logic [7:0] drive_8ma_bits;
    logic [7:0] pu;
    logic [7:0] pd;
  } gpm_clear_t;

  localparam gpm_clear_t GPM_CLEAR_NONE = '0;

endpackage

// ### gpm_pad_mode.sv
// Pin mode, drive strength and pull control of an eight-pin port
//
// Summary of operation
// RULE1: A set function-select bit gives the pin to the peripheral, a clear one to software.
// RULE2: After reset all pins are software inputs except the debug-port pins.
// RULE3: Function-select resets to 0x00, 0x80 on port B and 0x0f on port C.
// RULE4: Power-on and external reset both restore every pin default.
// RULE5: Software should not take debug pins at start-up and should keep a restore routine.
// RULE6: Drive select resets to 2 mA on every pin: 0xff, 0x00, 0x00.
// RULE7: Writing a one to a drive bit clears that pin in the other two drive fields.
// RULE8: That mutual clear takes effect on the second cycle after the write.
// RULE9: Drive writes act per pin; pins written zero keep their other fields.
// RULE10: A set open-drain bit makes the pad open drain; the field resets to zero.
// RULE11: Open-drain pins act as inputs with direction zero, outputs with one.
// RULE12: Software should also enable the digital input of open-drain pins.
// RULE13: A set pull-up bit enables the pull-up and clears that pin's pull-down.
// RULE14: Bits above the eight-bit field are reserved and preserved by software.
// RULE15: A set pull-down bit enables the pull-down and clears the pull-up two cycles on.
// RULE16: Under alternate function the peripheral's value and enable drive the pad.
// RULE17: Pad configuration is forwarded every cycle from the registers; pad_cfg is held at zero in reset up to the first clock after it.
module gpm_pad_mode
  import gpm_pkg::*;
#(
  parameter logic [7:0] ALT_RESET = GPM_RST_ALT
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output      logic [31:0]        prdata,
  output      logic               pready,
  output      logic               pslverr,
  // Pads
  input  wire logic [7:0]         pad_in,
  output      logic [7:0]         pad_out,
  output      logic [7:0]         pad_oe,
  output      gpm_pad_cfg_t       pad_cfg,
  // Alternate peripheral functions
  input  wire logic [7:0]         alt_out,
  input  wire logic [7:0]         alt_oe,
  output      logic [7:0]         alt_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0]   pin_data_q;
  logic [7:0]   pin_direction_q;
  logic [7:0]   alt_function_select_q;
  logic [7:0]   drive_2ma_select_q;
  logic [7:0]   drive_4ma_select_q;
  logic [7:0]   drive_8ma_select_q;
  logic [7:0]   open_drain_select_q;
  logic [7:0]   pull_up_select_q;
  logic [7:0]   pull_down_select_q;
  gpm_clear_t   clear_q;
  gpm_clear_t   clear_d;
  logic         pready_q;
  logic         pslverr_q;
  logic [31:0]  prdata_q;
  logic [7:0]   pad_out_q;
  logic [7:0]   pad_oe_q;
  logic [7:0]   alt_in_q;
  gpm_pad_cfg_t pad_cfg_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state so read data comes from a flop
  wire        acc_first = psel && penable && !pready_q;
  wire        wr_en     = psel && penable && pready_q && pwrite;
  wire [7:0]  wd        = pwdata[GPM_FIELD_MSB:GPM_FIELD_LSB];
  wire        hit_data  = paddr == GPM_OFF_DATA;
  wire        hit_dir   = paddr == GPM_OFF_DIR;
  wire        hit_alt   = paddr == GPM_OFF_ALT;
  wire        hit_dr2   = paddr == GPM_OFF_DR2;
  wire        hit_dr4   = paddr == GPM_OFF_DR4;
  wire        hit_dr8   = paddr == GPM_OFF_DR8;
  wire        hit_od    = paddr == GPM_OFF_OD;
  wire        hit_pu    = paddr == GPM_OFF_PU;
  wire        hit_pd    = paddr == GPM_OFF_PD;
  wire        hit_any   = hit_data | hit_dir | hit_alt | hit_dr2 | hit_dr4
                        | hit_dr8 | hit_od | hit_pu | hit_pd;
  wire        wr_data   = wr_en && hit_data;
  wire        wr_dir    = wr_en && hit_dir;
  wire        wr_alt    = wr_en && hit_alt;
  wire        wr_dr2    = wr_en && hit_dr2;
  wire        wr_dr4    = wr_en && hit_dr4;
  wire        wr_dr8    = wr_en && hit_dr8;
  wire        wr_od     = wr_en && hit_od;
  wire        wr_pu     = wr_en && hit_pu;
  wire        wr_pd     = wr_en && hit_pd;

  // Input pins read the pad, output pins read back the data latch
  wire [7:0]  data_view = (pad_in & ~pin_direction_q)
                        | (pin_data_q & pin_direction_q);
  // Reserved upper bits read as zero
  wire [7:0]  rd_field  = ({8{hit_data}} & data_view)
                        | ({8{hit_dir}}  & pin_direction_q)
                        | ({8{hit_alt}}  & alt_function_select_q)
                        | ({8{hit_dr2}}  & drive_2ma_select_q)
                        | ({8{hit_dr4}}  & drive_4ma_select_q)
                        | ({8{hit_dr8}}  & drive_8ma_select_q)
                        | ({8{hit_od}}   & open_drain_select_q)
                        | ({8{hit_pu}}   & pull_up_select_q)
                        | ({8{hit_pd}}   & pull_down_select_q); // RULE14
  wire [31:0] rd_word   = {24'h00_0000, rd_field};

  ////////////////////////////////////////////////////////////////////////////
  // Mutual clears; held one cycle so they land two cycles after the write
  always_comb begin
    clear_d      = GPM_CLEAR_NONE;
    clear_d.drive_2ma_bits = (wr_dr4 || wr_dr8) ? wd : 8'h00; // RULE7
    clear_d.drive_4ma_bits = (wr_dr2 || wr_dr8) ? wd : 8'h00; // RULE7
    clear_d.drive_8ma_bits = (wr_dr2 || wr_dr4) ? wd : 8'h00; // RULE7
    clear_d.pd   = wr_pu ? wd : 8'h00; // RULE13
    clear_d.pu   = wr_pd ? wd : 8'h00; // RULE15
  end

  // A fresh write wins over a clear still owed to the same field
  wire [7:0] dr2_d = wr_dr2 ? wd
                   : (drive_2ma_select_q & ~clear_q.drive_2ma_bits); // RULE8 RULE9
  wire [7:0] dr4_d = wr_dr4 ? wd
                   : (drive_4ma_select_q & ~clear_q.drive_4ma_bits); // RULE8 RULE9
  wire [7:0] dr8_d = wr_dr8 ? wd
                   : (drive_8ma_select_q & ~clear_q.drive_8ma_bits); // RULE8 RULE9
  wire [7:0] pu_d  = wr_pu ? wd
                   : (pull_up_select_q & ~clear_q.pu); // RULE15
  wire [7:0] pd_d  = wr_pd ? wd
                   : (pull_down_select_q & ~clear_q.pd); // RULE13

  ////////////////////////////////////////////////////////////////////////////
  // Pad steering
  wire [7:0] sel_val = (alt_function_select_q & alt_out)
                     | (~alt_function_select_q & pin_data_q); // RULE1 RULE16
  wire [7:0] sel_en  = (alt_function_select_q & alt_oe)
                     | (~alt_function_select_q & pin_direction_q); // RULE16
  // Open drain only ever pulls low; a high value releases the pad
  wire [7:0] out_d   = sel_val & ~open_drain_select_q; // RULE10
  wire [7:0] oe_d    = sel_en & ~(open_drain_select_q & sel_val); // RULE11
  gpm_pad_cfg_t cfg_d;
  assign cfg_d = '{drive_2ma_bits: drive_2ma_select_q, drive_4ma_bits: drive_4ma_select_q,
                   drive_8ma_bits: drive_8ma_select_q, od: open_drain_select_q,
                   pu: pull_up_select_q, pd: pull_down_select_q};

  ////////////////////////////////////////////////////////////////////////////
  // Registers; one reset input serves power-on and external reset alike
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_data_q            <= GPM_RST_DATA;
      pin_direction_q       <= GPM_RST_DIR; // RULE2
      alt_function_select_q <= ALT_RESET; // RULE2 RULE3 RULE4
    end else begin
      if (wr_data) pin_data_q <= wd;
      if (wr_dir)  pin_direction_q <= wd;
      if (wr_alt)  alt_function_select_q <= wd; // RULE1
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_2ma_select_q  <= GPM_RST_DR2; // RULE6
      drive_4ma_select_q  <= GPM_RST_DR4; // RULE6
      drive_8ma_select_q  <= GPM_RST_DR8; // RULE6
      open_drain_select_q <= GPM_RST_OD; // RULE10
      pull_up_select_q    <= GPM_RST_PU;
      pull_down_select_q  <= GPM_RST_PD;
      clear_q             <= GPM_CLEAR_NONE;
    end else begin
      drive_2ma_select_q  <= dr2_d;
      drive_4ma_select_q  <= dr4_d;
      drive_8ma_select_q  <= dr8_d;
      pull_up_select_q    <= pu_d;
      pull_down_select_q  <= pd_d;
      clear_q             <= clear_d; // RULE8
      if (wr_od) open_drain_select_q <= wd; // RULE10
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= GPM_RDATA_NONE;
    end else begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first && !hit_any;
      if (acc_first && !pwrite) prdata_q <= rd_word;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pad_out_q <= 8'h00;
      pad_oe_q  <= 8'h00;
      alt_in_q  <= 8'h00;
      pad_cfg_q <= '0;
    end else begin
      pad_out_q <= out_d;
      pad_oe_q  <= oe_d;
      alt_in_q  <= pad_in;
      pad_cfg_q <= cfg_d; // RULE17
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign pad_out = pad_out_q;
  assign pad_oe  = pad_oe_q;
  assign pad_cfg = pad_cfg_q;
  assign alt_in  = alt_in_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  wire wr_drv = wr_dr2 || wr_dr4 || wr_dr8;
  wire [7:0] alt_dir_mask = alt_function_select_q & ~open_drain_select_q;

  alt_route_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    1'b1 |=> (pad_out_q & $past(alt_dir_mask))
             == ($past(alt_out) & $past(alt_dir_mask)))
    else $error("alternate value not routed to pad");

  sw_route_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    1'b1 |=> ((pad_oe_q ^ $past(pin_direction_q))
             & $past(~alt_function_select_q & ~open_drain_select_q)) == 0)
    else $error("software direction not routed to pad");

  drv_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
    wr_dr2 ##1 !(wr_dr4 || wr_dr8) |=>
      ((drive_4ma_select_q | drive_8ma_select_q)
       & $past(pwdata[7:0], 2)) == 8'h00)
    else $error("drive write did not clear other strengths");

  drv_delay_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE8
    wr_dr4 |=> drive_2ma_select_q == $past(drive_2ma_select_q)
           && drive_8ma_select_q == $past(drive_8ma_select_q))
    else $error("drive clear landed too early");

  drv_keep_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE9
    wr_dr8 ##1 !wr_drv |=>
      ((drive_2ma_select_q ^ $past(drive_2ma_select_q, 2))
       & ~$past(pwdata[7:0], 2)) == 8'h00)
    else $error("drive write disturbed a pin written zero");

  od_low_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE11
    1'b1 |=> (pad_out_q & $past(open_drain_select_q)) == 8'h00
          && (pad_oe_q & $past(open_drain_select_q & ~sel_en)) == 8'h00)
    else $error("open-drain pad driven high");

  pull_pd_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
    wr_pu ##1 !wr_pd |=> (pull_down_select_q & $past(pwdata[7:0], 2))
                         == 8'h00)
    else $error("pull-up write did not clear pull-down");

  pull_pu_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
    wr_pd |=> pull_up_select_q == $past(pull_up_select_q))
    else $error("pull-up cleared too early");

  rsv_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    $rose(pready_q) && !pwrite |-> prdata_q[31:8] == 24'h00_0000)
    else $error("reserved read bits not zero");

  cfg_fwd_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
    1'b1 |=> pad_cfg_q.drive_2ma_bits == $past(drive_2ma_select_q)
          && pad_cfg_q.pu == $past(pull_up_select_q))
    else $error("pad configuration not forwarded");

  cfg_more_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
    1'b1 |=> pad_cfg_q.drive_4ma_bits == $past(drive_4ma_select_q)
          && pad_cfg_q.drive_8ma_bits == $past(drive_8ma_select_q)
          && pad_cfg_q.od == $past(open_drain_select_q)
          && pad_cfg_q.pd == $past(pull_down_select_q))
    else $error("drive, drain or pull-down not forwarded");

  alt_oe_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    1'b1 |=> (pad_oe_q & $past(alt_dir_mask))
             == ($past(alt_oe) & $past(alt_dir_mask)))
    else $error("alternate enable not routed to pad");

  alt_in_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE16
    1'b1 |=> alt_in_q == $past(pad_in))
    else $error("pad level not passed to peripheral");

  alt_store_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE1
    wr_alt |=> alt_function_select_q == $past(pwdata[7:0]))
    else $error("function select not stored");

  od_store_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE10
    wr_od |=> open_drain_select_q == $past(pwdata[7:0]))
    else $error("open-drain select not stored");

  drv_clr4_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
    wr_dr4 ##1 !(wr_dr2 || wr_dr8) |=>
      ((drive_2ma_select_q | drive_8ma_select_q)
       & $past(pwdata[7:0], 2)) == 8'h00)
    else $error("4 mA write did not clear other strengths");

  drv_clr8_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE7
    wr_dr8 ##1 !(wr_dr2 || wr_dr4) |=>
      ((drive_2ma_select_q | drive_4ma_select_q)
       & $past(pwdata[7:0], 2)) == 8'h00)
    else $error("8 mA write did not clear other strengths");

  pd_delay_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
    wr_pu |=> pull_down_select_q == $past(pull_down_select_q))
    else $error("pull-down cleared too early");

  pu_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE15
    wr_pd ##1 !wr_pu |=> (pull_up_select_q & $past(pwdata[7:0], 2))
                         == 8'h00)
    else $error("pull-down write did not clear pull-up");

  // Reset checks carry no disable, so they see the reset itself
  rst_mode_a: assert property (@(posedge clk) // RULE2 RULE3 RULE4
    !rst_b |=> alt_function_select_q == ALT_RESET
            && pin_direction_q == GPM_RST_DIR)
    else $error("pin mode not restored by reset");

  rst_drv_a: assert property (@(posedge clk) // RULE6
    !rst_b |=> drive_2ma_select_q == GPM_RST_DR2
            && drive_4ma_select_q == GPM_RST_DR4
            && drive_8ma_select_q == GPM_RST_DR8)
    else $error("drive strength not restored by reset");

  rst_od_a: assert property (@(posedge clk) // RULE10
    !rst_b |=> open_drain_select_q == GPM_RST_OD
            && pull_up_select_q == GPM_RST_PU
            && pull_down_select_q == GPM_RST_PD)
    else $error("drain and pull selects not restored by reset");

  alt_write_c: cover property (@(posedge clk) disable iff (!rst_b)
    wr_alt && wd != 8'h00);
  drv_swap_c:  cover property (@(posedge clk) disable iff (!rst_b)
    wr_dr2 ##1 wr_dr4);
  od_out_c:    cover property (@(posedge clk) disable iff (!rst_b)
    (open_drain_select_q & pin_direction_q) != 8'h00);
  err_c:       cover property (@(posedge clk) disable iff (!rst_b)
    pslverr_q);
  pull_c:      cover property (@(posedge clk) disable iff (!rst_b)
    wr_pd && wd != 8'h00);

endmodule

// ### gpm_pad_model.sv
// Behavioural model of the pads and board wiring behind the port pins
module gpm_pad_model
  import gpm_pkg::*;
(
  // Pad side of the port
  input  wire logic [7:0]   pad_out,
  input  wire logic [7:0]   pad_oe,
  input  wire gpm_pad_cfg_t pad_cfg,
  output      logic [7:0]   pad_in,
  // Board driver
  input  wire logic [7:0]   ext_lvl,
  input  wire logic [7:0]   ext_en
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////
  // Floating pins read the inverse of pad_out, so a stale
  // level never passes as a match
  // Digital input always on, open-drain pins included
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_lvl[i];
      else if (pad_cfg.pu[i] || pad_cfg.pd[i])
        pad_in[i] = pad_cfg.pu[i];
      else
        pad_in[i] = ~pad_out[i];
    end
  end
endmodule

// ### tb_gpio_pad_mode_control.sv
// Self-checking bench of the pad mode block
module tb_gpio_pad_mode_control
  import gpm_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [11:0] COFF [6] = '{GPM_OFF_DR2, GPM_OFF_DR4,
    GPM_OFF_DR8, GPM_OFF_OD, GPM_OFF_PU, GPM_OFF_PD};
  logic               clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, seed, q, r;
  logic [7:0]         pad_in, pad_out, pad_oe, alt_in, alt_out, alt_oe;
  logic [7:0]         ext_lvl, ext_en, a, d, x, od, eo, ee;
  logic               e;
  gpm_pad_cfg_t       pad_cfg;
  logic [0:5][7:0]    m_cfg;
  int                 failures, n_compared;
  gpm_pad_mode #(.ALT_RESET(GPM_RST_ALT_C)) i_dut (.clk(clk),
    .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_cfg(pad_cfg), .alt_out(alt_out),
    .alt_oe(alt_oe), .alt_in(alt_in));
  gpm_pad_model i_pads (.pad_out(pad_out), .pad_oe(pad_oe),
    .pad_cfg(pad_cfg), .pad_in(pad_in), .ext_lvl(ext_lvl),
    .ext_en(ext_en));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Upper bits always written as zero, the value they read back
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] ad, input logic [7:0] exp);
    apb(1'b0, ad, 8'h00);
    check({16'h0, q}, {40'h0, exp});
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    m_cfg = {GPM_RST_DR2, GPM_RST_DR4, GPM_RST_DR8, GPM_RST_OD,
             GPM_RST_PU, GPM_RST_PD};
    repeat (2) @(posedge clk);
    #1;
    check(pad_cfg, m_cfg);
    rd_chk(GPM_OFF_ALT, GPM_RST_ALT_C);
    rd_chk(GPM_OFF_DIR, GPM_RST_DIR);
    for (int j = 0; j < 6; j++) rd_chk(COFF[j], m_cfg[j]);
    $display("reset test done");
  endtask
  // Clears land one edge after the write edge, not with it
  task automatic cfg_write(input int t, input logic [7:0] v);
    m_cfg[t] = v;
    apb(1'b1, COFF[t], v);
    @(posedge clk);
    #1;
    check(pad_cfg, m_cfg);
    for (int j = 0; j < 6; j++) begin
      if (j != t && j != 3 && t != 3 && (t < 3) == (j < 3))
        m_cfg[j] &= ~v;
    end
    @(posedge clk);
    #1;
    check(pad_cfg, m_cfg);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(5000 * 8);
    failures++;
    print_verdict();
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {alt_out, alt_oe, ext_lvl, ext_en} = '0;
    failures = 0;
    n_compared = 0;
    seed = 32'h261914b7;
    do_reset();
    for (int k = 0; k < 18; k++) begin
      r = xs();
      cfg_write(k % 6, k < 6 ? 8'hff : (k > 15 ? 8'h00 : r[7:0]));
    end
    for (int j = 0; j < 6; j++) rd_chk(COFF[j], m_cfg[j]);
    $display("drive and pull test done");
    for (int k = 0; k < 6; k++) begin
      r = xs();
      {a, d, x, od} = r;
      if (k > 2) a = 8'h00;
      od = k > 2 ? od : 8'h00;
      r = xs();
      apb(1'b1, GPM_OFF_ALT, a);
      {alt_out, alt_oe, ext_lvl, ext_en} <= r;
      apb(1'b1, GPM_OFF_DIR, d);
      apb(1'b1, GPM_OFF_DATA, x);
      cfg_write(3, od);
      repeat (2) @(posedge clk);
      #1;
      eo = (a & alt_out) | (~a & ~od & x);
      ee = (a & alt_oe) | (~a & d & ~(od & x));
      check(pad_out, eo);
      check(pad_oe, ee);
      check(alt_in & (ee | ext_en),
            (eo & ee) | (ext_lvl & ext_en & ~ee));
      apb(1'b0, GPM_OFF_DATA, 8'h00);
      check(q[7:0] & (d | (~a & ext_en)),
            (x & d) | (ext_lvl & ext_en & ~a & ~d));
    end
    $display("pad control test done");
    apb(1'b1, 12'h5fc, 8'hff);
    check(e, 1'b1);
    apb(1'b0, 12'h5fc, 8'h00);
    check({e, q}, {1'b1, 32'h0});
    $display("unmapped test done");
    do_reset();
    print_verdict();
  end
endmodule
